// file: rop_pkg.sv
// constants and types of the ring overload protection block
// assumes a single 25 MHz clock and an axi4-lite register slave
package rop_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int SLOW_HZ = 96_000;
  localparam int FAST_HZ = 307_200;
  // pwm periods in clocks, rounded down
  localparam logic [8:0] PER_SLOW = 9'(CLK_HZ / SLOW_HZ);
  localparam logic [8:0] PER_FAST = 9'(CLK_HZ / FAST_HZ);
  localparam int ARM_MS = 300;
  localparam int ARM_CYC = ARM_MS * (CLK_HZ / 1000);
  localparam int SHUT_MS = 4860;
  localparam int SHUT_CYC = SHUT_MS * (CLK_HZ / 1000);
  localparam int TMR_W = 27;
  localparam logic [4:0] STEP_NOM = 5'h10;
  localparam logic [4:0] STEP_MAX = 5'h1f;
  localparam logic [4:0] IDX_LAST = 5'h1f;
  localparam logic [7:0] EVT_THRESH = 8'h04;
  localparam logic [7:0] EVT_SAT = 8'hff;
  localparam logic [1:0] NOM_FULL = 2'h1;
  // register map, byte addresses
  localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] ADDR_SEG = 32'h0000_0004;
  localparam logic [31:0] ADDR_STAT = 32'h0000_0008;
  localparam int CTRL_DIS = 0;
  localparam int CTRL_FAST = 1;
  localparam logic [15:0] SEG_RST = 16'h004b;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // quarter sine, entry 15 first
  localparam logic [15:0][7:0] SINE_Q = {
    8'hff, 8'hfe, 8'hfa, 8'hf4, 8'hec, 8'he1, 8'hd4, 8'hc5,
    8'hb4, 8'ha2, 8'h8e, 8'h78, 8'h62, 8'h4a, 8'h32, 8'h19};

  typedef enum logic [1:0] {ST_RUN, ST_ARM, ST_SHUT} rop_prot_e;

  typedef struct packed {
    logic dis;
    logic fast;
    logic [15:0] seg;
  } rop_ctrl_s;

  typedef struct packed {
    logic cmp;
    logic [1:0] prot;
    logic rpt;
    logic [4:0] step;
    logic [7:0] evt_cnt;
  } rop_stat_s;
endpackage

// file: rop_regs.sv
// axi4-lite register slave of the ring overload protection block
// assumes one write and one read outstanding at most
`timescale 1ns/1ps
module rop_regs import rop_pkg::*; (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // write address and data
  input wire logic [31:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  // write response
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  // read
  input wire logic [31:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  // block side
  output rop_ctrl_s ctrl_o,
  input wire rop_stat_s stat_i
);
  typedef struct packed {
    logic aw_have;
    logic [31:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    rop_ctrl_s ctrl;
  } rop_axi_s;

  rop_axi_s q;
  rop_axi_s next_q;

  // address and data are taken in either order
  always_comb begin
    next_q = q;
    if (awvalid_i && q.awready) begin
      next_q.aw_have = 1'b1;
      next_q.awaddr = awaddr_i;
    end
    if (wvalid_i && q.wready) begin
      next_q.w_have = 1'b1;
      next_q.wdata = wdata_i;
      next_q.wstrb = wstrb_i;
    end
    if (bready_i && q.bvalid) begin
      next_q.bvalid = 1'b0;
    end
    if (q.aw_have && q.w_have && !q.bvalid) begin
      next_q.aw_have = 1'b0;
      next_q.w_have = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.bresp = RESP_OK;
      if (q.awaddr == ADDR_CTRL) begin
        if (q.wstrb[0]) begin
          next_q.ctrl.dis = q.wdata[CTRL_DIS];
          next_q.ctrl.fast = q.wdata[CTRL_FAST];
        end
      end else if (q.awaddr == ADDR_SEG) begin
        if (q.wstrb[0]) next_q.ctrl.seg[7:0] = q.wdata[7:0];
        if (q.wstrb[1]) next_q.ctrl.seg[15:8] = q.wdata[15:8];
      end else if (q.awaddr != ADDR_STAT) begin
        next_q.bresp = RESP_ERR; // unmapped
      end
    end
    // ready is registered so every port comes from a flop
    next_q.awready = !next_q.aw_have && !next_q.bvalid;
    next_q.wready = !next_q.w_have && !next_q.bvalid;
    if (rready_i && q.rvalid) begin
      next_q.rvalid = 1'b0;
    end
    if (arvalid_i && q.arready) begin
      next_q.rvalid = 1'b1;
      next_q.rresp = RESP_OK;
      next_q.rdata = '0;
      unique case (araddr_i)
        ADDR_CTRL: next_q.rdata[1:0] = {q.ctrl.fast, q.ctrl.dis};
        ADDR_SEG: next_q.rdata[15:0] = q.ctrl.seg;
        ADDR_STAT: next_q.rdata[$bits(rop_stat_s)-1:0] = stat_i;
        default: next_q.rresp = RESP_ERR;
      endcase
    end
    next_q.arready = !next_q.rvalid;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.ctrl.seg <= SEG_RST;
    end else begin
      q <= next_q;
    end
  end

  assign awready_o = q.awready;
  assign wready_o = q.wready;
  assign bvalid_o = q.bvalid;
  assign bresp_o = q.bresp;
  assign arready_o = q.arready;
  assign rvalid_o = q.rvalid;
  assign rresp_o = q.rresp;
  assign rdata_o = q.rdata;
  assign ctrl_o = q.ctrl;
endmodule

// file: rop_stage_model.sv
// flyback power stage and current sense model for the overload block
// assumes switch_drive_i comes straight from the block, sense pulled up
`timescale 1ns/1ps
module rop_stage_model (
  // clock
  input wire logic clk_i,
  // control from the testbench and the block
  input wire logic switch_drive_i,
  input wire logic overload_i,
  input wire logic [3:0] trip_i,
  // sense pins back to the block
  output logic current_sense_n_o,
  output logic comparator_in_o
);
  logic [3:0] on_cnt = 4'h0;

  // no line compensation fitted, comparator held low
  assign comparator_in_o = 1'b0;

  // switch on-time, saturating so long pulses stay tripped
  always @(posedge clk_i) begin
    if (!switch_drive_i) on_cnt <= 4'h0;
    else if (on_cnt != 4'hf) on_cnt <= on_cnt + 4'h1;
  end

  // overloaded stage trips after trip_i clocks; pull-up once switch is off
  assign current_sense_n_o = !(overload_i && switch_drive_i &&
    (on_cnt >= trip_i));
endmodule

// file: rop_top.sv
// ring overload protection: pwm, current limit, amplitude, shutdown
// assumes current_sense_n_i and comparator_in_i are async pins
// Summary of operation
// - sense low cuts pulse until period end
// - count limit events per half cycle
// - amplitude equals nominal times sixteen over step
// - step rests at 16, rises up to 31
// - no events: step down once per half
// - overload report high while step above 16
// - report clears after full period at 16
// - report pulse lasts one sine cycle minimum
// - overload detected within one half cycle
// - minimum amplitude overload starts 300 ms timer
// - overload at expiry: switch off 4.86 s
// - resume switching at minimum amplitude step
// - persisting overload repeats timer and shutdown
// - load gone: amplitude rises step by step
// - onset to shutdown within 8 cycles+300ms
// - all timing counted on main clock
// - duty from sine table, transfer, step
// - bridge phase square wave at sine rate
// - warning pulse just before zero crossing
// - switch off shortly after sense goes low
// - disable bit turns output off
// - fast rate: immediate, slow: at crossing
`timescale 1ns/1ps
module rop_top import rop_pkg::*; #(
  parameter int unsigned ARM_CYCLES = ARM_CYC,
  parameter int unsigned SHUT_CYCLES = SHUT_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // axi4-lite write
  input wire logic [31:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  // axi4-lite read
  input wire logic [31:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  // power stage pins
  input wire logic current_sense_n_i,
  input wire logic comparator_in_i,
  output logic switch_drive_o,
  output logic overload_report_o,
  output logic bridge_phase_o,
  output logic zero_warn_o
);
  // timers must fit the shared down counter
  if (ARM_CYCLES < 1 || ARM_CYCLES >= (1 << TMR_W) ||
      SHUT_CYCLES < 1 || SHUT_CYCLES >= (1 << TMR_W)) begin : g_chk
    $error("rop_top: timer parameter out of range");
  end

  typedef struct packed {
    logic [2:0] cs_sync;
    logic [1:0] cmp_sync;
    logic [8:0] pc;
    logic [8:0] duty;
    logic [15:0] seg_cnt;
    logic [4:0] idx;
    logic cut;
    logic pwm;
    logic [7:0] evt_cnt;
    logic ovl_half;
    logic [4:0] step;
    logic rpt;
    logic [1:0] nom_halves;
    rop_prot_e prot;
    logic [TMR_W-1:0] tmr;
    logic dis;
    logic phase;
    logic warn;
    logic half_end;
  } rop_core_s;

  rop_core_s q;
  rop_core_s next_q;
  rop_ctrl_s ctrl;
  rop_stat_s stat;
  logic [8:0] per;
  logic per_end;
  logic seg_last;
  logic evt_fall;
  logic over;

  localparam logic [TMR_W-1:0] ARM_LOAD = TMR_W'(ARM_CYCLES - 1);
  localparam logic [TMR_W-1:0] SHUT_LOAD = TMR_W'(SHUT_CYCLES - 1);

  // duty = table * period / 256, times 16 over step
  function automatic logic [8:0] duty_of(logic [4:0] i,
                                         logic [4:0] st,
                                         logic [8:0] p);
    logic [3:0] qi;
    logic [16:0] prod;
    logic [12:0] sc;
    qi = i[4] ? ~i[3:0] : i[3:0];
    prod = 17'(SINE_Q[qi]) * 17'(p);
    sc = {prod[16:8], 4'h0};
    return 9'(sc / 13'(st));
  endfunction

  rop_regs i_rop_regs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .awaddr_i(awaddr_i),
    .awvalid_i(awvalid_i),
    .awready_o(awready_o),
    .wdata_i(wdata_i),
    .wstrb_i(wstrb_i),
    .wvalid_i(wvalid_i),
    .wready_o(wready_o),
    .bresp_o(bresp_o),
    .bvalid_o(bvalid_o),
    .bready_i(bready_i),
    .araddr_i(araddr_i),
    .arvalid_i(arvalid_i),
    .arready_o(arready_o),
    .rdata_o(rdata_o),
    .rresp_o(rresp_o),
    .rvalid_o(rvalid_o),
    .rready_i(rready_i),
    .ctrl_o(ctrl),
    .stat_i(stat)
  );

  // status seen by software
  assign stat.cmp = q.cmp_sync[1];
  assign stat.prot = q.prot;
  assign stat.rpt = q.rpt;
  assign stat.step = q.step;
  assign stat.evt_cnt = q.evt_cnt;

  // period and segment boundaries
  assign per = ctrl.fast ? PER_FAST : PER_SLOW;
  assign per_end = q.pc >= per - 9'h1;
  assign seg_last = {1'b0, q.seg_cnt} + 17'h1 >= {1'b0, ctrl.seg};
  // edge seen on second and third flop only
  assign evt_fall = q.cs_sync[2] & ~q.cs_sync[1];
  assign over = q.evt_cnt > EVT_THRESH;

  always_comb begin
    next_q = q;
    next_q.cs_sync = {q.cs_sync[1:0], current_sense_n_i};
    next_q.cmp_sync = {q.cmp_sync[0], comparator_in_i};
    next_q.half_end = 1'b0;
    next_q.pc = per_end ? 9'h0 : q.pc + 9'h1;
    // cut holds for the rest of the period
    next_q.cut = !per_end && (q.cut || !q.cs_sync[1]);
    if (evt_fall && q.evt_cnt != EVT_SAT) begin
      next_q.evt_cnt = q.evt_cnt + 8'h1;
    end
    // sine position advances once every ctrl.seg pwm periods
    if (per_end) begin
      next_q.seg_cnt = seg_last ? 16'h0 : q.seg_cnt + 16'h1;
      if (seg_last) begin
        next_q.idx = q.idx + 5'h1;
        next_q.half_end = q.idx == IDX_LAST;
      end
    end
    // half-cycle bookkeeping at the zero crossing
    if (q.half_end) begin
      next_q.phase = ~q.phase;
      next_q.evt_cnt = {7'h0, evt_fall};
      next_q.ovl_half = q.evt_cnt != 8'h0;
      if (q.prot != ST_SHUT) begin
        if (over && q.step != STEP_MAX) begin
          next_q.step = q.step + 5'h1;
        end else if (q.evt_cnt == 8'h0 && q.step != STEP_NOM) begin
          next_q.step = q.step - 5'h1;
        end
      end
      if (q.rpt && q.step == STEP_NOM && q.nom_halves != 2'h3) begin
        next_q.nom_halves = q.nom_halves + 2'h1;
      end
      // one full period at nominal before the report drops
      if (q.rpt && q.step == STEP_NOM && q.nom_halves == NOM_FULL) begin
        next_q.rpt = 1'b0;
      end
    end
    if (next_q.step > STEP_NOM) begin
      next_q.rpt = 1'b1;
      next_q.nom_halves = 2'h0;
    end
    // sequencer on clk_i; arms as the floor step is reached, so
    // onset to shutdown stays within eight cycles plus the timer
    unique case (q.prot)
      ST_RUN: begin
        if (q.half_end && over && q.step >= STEP_MAX - 5'h1) begin
          next_q.prot = ST_ARM;
          next_q.tmr = ARM_LOAD;
        end
      end
      ST_ARM: begin
        next_q.tmr = q.tmr - TMR_W'(1);
        if (q.half_end && q.evt_cnt == 8'h0) begin
          next_q.prot = ST_RUN;
        end else if (q.tmr == '0) begin
          if (q.ovl_half || q.evt_cnt != 8'h0) begin
            next_q.prot = ST_SHUT;
            next_q.tmr = SHUT_LOAD;
          end else begin
            next_q.prot = ST_RUN;
          end
        end
      end
      ST_SHUT: begin
        next_q.tmr = q.tmr - TMR_W'(1);
        if (q.tmr == '0) begin
          next_q.prot = ST_RUN;
          next_q.step = STEP_MAX;
          next_q.evt_cnt = 8'h0;
        end
      end
    endcase
    // slow rate waits for the crossing, fast acts now
    if (!ctrl.dis) begin
      next_q.dis = 1'b0;
    end else if (ctrl.fast || q.half_end) begin
      next_q.dis = 1'b1;
    end
    next_q.duty = duty_of(next_q.idx, next_q.step, per);
    next_q.pwm = !q.dis && q.prot != ST_SHUT &&
                 next_q.pc < q.duty && q.cs_sync[1] &&
                 (per_end || !q.cut);
    next_q.warn = next_q.idx == IDX_LAST;
  end

  // one register stage for the whole core
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.cs_sync <= 3'h7;
      q.step <= STEP_NOM;
      q.prot <= ST_RUN;
    end else begin
      q <= next_q;
    end
  end

  assign switch_drive_o = q.pwm;
  assign overload_report_o = q.rpt;
  assign bridge_phase_o = q.phase;
  assign zero_warn_o = q.warn;

  // halves of report high, for the pulse length check
  logic [1:0] hp_halves;
  always_ff @(posedge clk_i) begin
    if (rst_i || !q.rpt) begin
      hp_halves <= 2'h0;
    end else if (q.half_end && hp_halves != 2'h3) begin
      hp_halves <= hp_halves + 2'h1;
    end
  end

  property p_cut;
    @(posedge clk_i) disable iff (rst_i)
      !q.cs_sync[1] |=> !switch_drive_o;
  endproperty
  a_cut: assert property (p_cut)
    else $error("switch drive stayed on with sense low");

  property p_hold_cut;
    @(posedge clk_i) disable iff (rst_i)
      q.cut && !per_end |=> !switch_drive_o;
  endproperty
  a_hold_cut: assert property (p_hold_cut)
    else $error("pulse restarted inside a cut period");

  property p_cnt_clr;
    @(posedge clk_i) disable iff (rst_i)
      q.half_end |=> q.evt_cnt <= 8'h1;
  endproperty
  a_cnt_clr: assert property (p_cnt_clr)
    else $error("event counter not cleared at crossing");

  property p_step_rng;
    @(posedge clk_i) disable iff (rst_i)
      q.step >= STEP_NOM && q.step <= STEP_MAX;
  endproperty
  a_step_rng: assert property (p_step_rng)
    else $error("step outside 16 to 31");

  property p_step_one;
    @(posedge clk_i) disable iff (rst_i)
      q.prot != ST_SHUT && q.step != $past(q.step) |->
        $past(q.half_end) &&
        (q.step == $past(q.step) + 5'h1 ||
         q.step == $past(q.step) - 5'h1);
  endproperty
  a_step_one: assert property (p_step_one)
    else $error("step moved off a crossing or by more than one");

  property p_rpt;
    @(posedge clk_i) disable iff (rst_i)
      q.step > STEP_NOM |-> overload_report_o;
  endproperty
  a_rpt: assert property (p_rpt)
    else $error("report low with reduced amplitude");

  property p_rpt_min;
    @(posedge clk_i) disable iff (rst_i)
      $fell(overload_report_o) |-> $past(hp_halves) >= 2'h2;
  endproperty
  a_rpt_min: assert property (p_rpt_min)
    else $error("report pulse shorter than one sine cycle");

  property p_shut_off;
    @(posedge clk_i) disable iff (rst_i)
      q.prot == ST_SHUT ##1 q.prot == ST_SHUT |-> !switch_drive_o;
  endproperty
  a_shut_off: assert property (p_shut_off)
    else $error("switching during shutdown");

  property p_resume;
    @(posedge clk_i) disable iff (rst_i)
      q.prot == ST_SHUT && q.tmr == '0 |=>
        q.prot == ST_RUN && q.step == STEP_MAX;
  endproperty
  a_resume: assert property (p_resume)
    else $error("did not resume at minimum amplitude");

  property p_phase;
    @(posedge clk_i) disable iff (rst_i)
      q.half_end |=> bridge_phase_o != $past(bridge_phase_o);
  endproperty
  a_phase: assert property (p_phase)
    else $error("bridge phase missed a crossing");

  property p_dis_fast;
    @(posedge clk_i) disable iff (rst_i)
      ctrl.dis && ctrl.fast ##1 ctrl.dis |=> !switch_drive_o;
  endproperty
  a_dis_fast: assert property (p_dis_fast)
    else $error("fast disable did not stop output");

  c_shut: cover property (@(posedge clk_i) disable iff (rst_i)
    q.prot == ST_ARM ##1 q.prot == ST_SHUT);
  c_rpt: cover property (@(posedge clk_i) disable iff (rst_i)
    $fell(overload_report_o));
  c_step_max: cover property (@(posedge clk_i) disable iff (rst_i)
    $rose(q.step == STEP_MAX));
endmodule

// file: rop_top_tb.sv
// self-checking bench of rop_top: registers, timing, overload protection
// assumes the stage model, shortened arm and shutdown counts
`timescale 1ns/1ps
module rop_top_tb;
  import rop_pkg::*;
  localparam int ARM_T = 200;
  localparam int SHUT_T = 400;
  localparam int HALF = 32 * int'(PER_FAST);
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [31:0] awaddr_i = '0;
  logic [31:0] wdata_i = '0;
  logic [31:0] araddr_i = '0;
  logic [3:0] wstrb_i = '0;
  logic awvalid_i = 1'b0;
  logic wvalid_i = 1'b0;
  logic bready_i = 1'b0;
  logic arvalid_i = 1'b0;
  logic rready_i = 1'b0;
  logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
  logic [1:0] bresp_o, rresp_o;
  logic [31:0] rdata_o;
  logic current_sense_n_i, comparator_in_i;
  logic switch_drive_o, overload_report_o, bridge_phase_o, zero_warn_o;
  logic ovl = 1'b0;
  logic [3:0] trip = 4'h5;
  logic [3:0] sh = 4'hf;
  logic [31:0] exp_rd[$], exp_rm[$];
  logic [1:0] exp_rr[$], exp_b[$];
  logic [31:0] d;
  int fails = 0;
  int checks_done = 0;
  int seed = 10712;
  int cyc = 0;
  int n, w, h, t0;

  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;

  rop_top #(.ARM_CYCLES(ARM_T), .SHUT_CYCLES(SHUT_T)) i_rop_top (
    .clk_i(clk_i), .rst_i(rst_i),
    .awaddr_i(awaddr_i), .awvalid_i(awvalid_i), .awready_o(awready_o),
    .wdata_i(wdata_i), .wstrb_i(wstrb_i), .wvalid_i(wvalid_i),
    .wready_o(wready_o), .bresp_o(bresp_o), .bvalid_o(bvalid_o),
    .bready_i(bready_i), .araddr_i(araddr_i), .arvalid_i(arvalid_i),
    .arready_o(arready_o), .rdata_o(rdata_o), .rresp_o(rresp_o),
    .rvalid_o(rvalid_o), .rready_i(rready_i),
    .current_sense_n_i(current_sense_n_i),
    .comparator_in_i(comparator_in_i), .switch_drive_o(switch_drive_o),
    .overload_report_o(overload_report_o),
    .bridge_phase_o(bridge_phase_o), .zero_warn_o(zero_warn_o));

  rop_stage_model i_rop_stage_model (
    .clk_i(clk_i), .switch_drive_i(switch_drive_o), .overload_i(ovl),
    .trip_i(trip), .current_sense_n_o(current_sense_n_i),
    .comparator_in_o(comparator_in_i));

  task automatic chk(input logic [31:0] got, exp, m);
    checks_done++;
    if ((got & m) !== (exp & m)) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // write: address and data offered together, bready held until answer
  task automatic wr(input logic [31:0] a, v, input logic [3:0] s,
                    input logic [1:0] er);
    @(posedge clk_i);
    exp_b.push_back(er);
    awaddr_i <= a;
    wdata_i <= v;
    wstrb_i <= s;
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    bready_i <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awready_o) awvalid_i <= 1'b0;
      if (wready_o) wvalid_i <= 1'b0;
    end while (!(bvalid_o && bready_i));
    bready_i <= 1'b0;
  endtask

  // read: expectation noted first, monitor compares on rvalid
  task automatic rdx(input logic [31:0] a, e, m, input logic [1:0] er,
                     output logic [31:0] v);
    @(posedge clk_i);
    exp_rd.push_back(e);
    exp_rm.push_back(m);
    exp_rr.push_back(er);
    araddr_i <= a;
    arvalid_i <= 1'b1;
    rready_i <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arready_o) arvalid_i <= 1'b0;
    end while (!(rvalid_o && rready_i));
    v = rdata_o;
    rready_i <= 1'b0;
  endtask

  // status polling, spaced out so slow protection steps fit the run
  task automatic poll(input logic [31:0] m, v, input int lim);
    int k;
    k = 0;
    do begin
      repeat (60) @(posedge clk_i);
      rdx(ADDR_STAT, 32'h0, 32'h0, RESP_OK, d);
      k++;
    end while ((d & m) !== v && k < lim);
    chk(d, v, m);
  endtask

  // clocks until bridge phase changes, and warning clocks meanwhile
  task automatic half_len;
    logic b;
    n = 0;
    w = 0;
    b = bridge_phase_o;
    do begin
      @(posedge clk_i);
      n++;
      w += int'(zero_warn_o);
    end while (bridge_phase_o === b && n < 4 * HALF);
  endtask

  task automatic highs(input int len);
    h = 0;
    repeat (len) begin
      @(posedge clk_i);
      h += int'(switch_drive_o);
    end
  endtask

  // response monitor, oldest note first
  always @(posedge clk_i) begin
    if (rvalid_o && rready_i) begin
      chk(rdata_o, exp_rd.pop_front(), exp_rm.pop_front());
      chk(32'(rresp_o), 32'(exp_rr.pop_front()), '1);
    end
    if (bvalid_o && bready_i) chk(32'(bresp_o), 32'(exp_b.pop_front()), '1);
  end

  // sense fall first sampled three edges ago: switch must be off now
  always @(posedge clk_i) begin
    sh <= {sh[2:0], current_sense_n_i};
    if (!rst_i && sh[3:2] == 2'b10) chk(32'(switch_drive_o), 0, '1);
  end

  // trip delay varies so the stage answers both promptly and slowly
  always @(posedge bridge_phase_o) trip <= 4'(2 + {$random(seed)} % 8);

  initial begin
    // a clean run needs below about 98,000 clocks at worst
    repeat (102000) @(posedge clk_i);
    fails++;
    tally_and_finish();
  end

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdx(ADDR_CTRL, 32'h0, 32'h3, RESP_OK, d);
    rdx(ADDR_SEG, 32'(SEG_RST), 32'hffff, RESP_OK, d);
    rdx(ADDR_STAT, 32'h1000, 32'h1ffff, RESP_OK, d);
    rdx(32'h0000_000c, 32'h0, 32'h0, RESP_ERR, d);
    wr(32'h0000_000c, 32'h1, 4'hf, RESP_ERR);
    d = $random(seed);
    wr(ADDR_SEG, d, 4'h3, RESP_OK);
    wr(ADDR_SEG, 32'h0000_5aa5, 4'h1, RESP_OK);
    rdx(ADDR_SEG, {16'h0, d[15:8], 8'ha5}, 32'hffff, RESP_OK, d);
    wr(ADDR_SEG, 32'h1, 4'hf, RESP_OK);
    wr(ADDR_CTRL, 32'h2, 4'hf, RESP_OK);
    half_len();
    half_len();
    chk(32'(n), 32'(HALF), '1);
    chk(32'(w), 32'(PER_FAST), '1);
    chk(32'(n), 32'(HALF), '1);
    // disable at fast rate acts at once
    wr(ADDR_CTRL, 32'h3, 4'hf, RESP_OK);
    repeat (3) @(posedge clk_i);
    highs(2 * int'(PER_FAST));
    chk(32'(h), 0, '1);
    wr(ADDR_CTRL, 32'h2, 4'hf, RESP_OK);
    highs(2 * int'(PER_FAST));
    chk(32'(h != 0), 1, '1);
    // overload: step climbs to the floor of the amplitude range
    ovl <= 1'b1;
    t0 = cyc;
    poll(32'h1f00, 32'h1f00, 800);
    chk(32'(overload_report_o), 1, '1);
    poll(32'hc000, 32'h8000, 120);
    chk(32'((cyc - t0) <= 16 * HALF + ARM_T + 200), 1, '1);
    highs(SHUT_T - 150);
    chk(32'(h), 0, '1);
    poll(32'hdf00, 32'h5f00, 200);
    poll(32'hc000, 32'h8000, 200);
    // load gone: step walks back to nominal
    ovl <= 1'b0;
    poll(32'h1f00, 32'h1000, 900);
    chk(32'(overload_report_o), 1, '1);
    n = 0;
    while (overload_report_o === 1'b1 && n < 4 * HALF) begin
      @(posedge clk_i);
      n++;
    end
    chk(32'(n >= 2 * HALF - 100 && n <= 3 * HALF), 1, '1);
    rdx(ADDR_STAT, 32'h1000, 32'h3f00, RESP_OK, d);
    tally_and_finish();
  end
endmodule
